// ---- inc/pst_pkg.sv ----
// Package with register map, field layout, reset values and carrier types of the pulse sequence timer
package pst_pkg;
	// Register address width and data width of the plain register port
	localparam int ADDR_W = 8;
	localparam int DATA_W = 24;
	localparam int CNT_W = 16;

	// Register offsets
	localparam logic [7:0] OFS_AMB1_CONV_START = 8'h13;
	localparam logic [7:0] OFS_AMB1_CONV_END = 8'h14;
	localparam logic [7:0] OFS_ADC_RST0_START = 8'h15;
	localparam logic [7:0] OFS_ADC_RST0_END = 8'h16;
	localparam logic [7:0] OFS_ADC_RST1_START = 8'h17;
	localparam logic [7:0] OFS_ADC_RST1_END = 8'h18;
	localparam logic [7:0] OFS_ADC_RST2_START = 8'h19;
	localparam logic [7:0] OFS_ADC_RST2_END = 8'h1A;
	localparam logic [7:0] OFS_ADC_RST3_START = 8'h1B;
	localparam logic [7:0] OFS_ADC_RST3_END = 8'h1C;
	localparam logic [7:0] OFS_REP_PERIOD = 8'h1D;
	localparam logic [7:0] OFS_CONTROL = 8'h1E;
	localparam logic [7:0] OFS_SPARE = 8'h1F;
	localparam logic [7:0] OFS_STATUS = 8'h30;

	// Count register bank: contiguous from the first offset, index is offset minus base
	localparam int NUM_CNT = 11;
	localparam int IDX_AMB1_START = 0;
	localparam int IDX_AMB1_END = 1;
	localparam int IDX_RST_BASE = 2;
	localparam int IDX_REP_PERIOD = 10;
	localparam logic [7:0] CNT_BASE_OFS = OFS_AMB1_CONV_START;

	// Control register field positions
	localparam int CTRL_SEL_LSB = 9;
	localparam int CTRL_SEL_MSB = 11;
	localparam int CTRL_EN_BIT = 8;
	localparam int CTRL_ONE_BIT = 1;

	// Values after reset
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [2:0] SEL_RESET = 3'h0;
	localparam logic [23:0] SPARE_RESET = 24'h000000;

	// Timebase: an enable pulse at TB_KHZ derived from REF_KHZ by a phase accumulator
	localparam int REF_KHZ = 50000;
	localparam int TB_KHZ = 4000;
	localparam int ACC_W = 16;

	// Diagnostic pin selector codes
	typedef enum logic [2:0] {
		SEL_SAMPLE = 3'b000,
		SEL_LED_PULSE = 3'b001,
		SEL_AMB_SAMPLE = 3'b010,
		SEL_CONVERT = 3'b011,
		SEL_AMB_CONVERT = 3'b100
	} diag_sel_t;

	// Phase signals toward the analog front end
	typedef struct packed {
		logic amb1_convert;
		logic [3:0] adc_reset;
	} phase_t;

	// Per-emitter phase signals made elsewhere in the engine
	typedef struct packed {
		logic sample;
		logic led_pulse;
		logic amb_sample;
		logic convert;
		logic amb_convert;
	} side_src_t;

	typedef struct packed {
		side_src_t led2;
		side_src_t led1;
	} diag_src_t;
endpackage

// ---- logic/tb_tick_gen.sv ----
// Timebase enable generator: one-cycle pulses at the timebase rate from the reference clock
`timescale 1ns/1ns
`default_nettype none
module tb_tick_gen #(
	parameter int REF_KHZ = pst_pkg::REF_KHZ,
	parameter int TB_KHZ = pst_pkg::TB_KHZ
) (
	input wire logic ref_clk,
	input wire logic rstn,
	output logic tick_q
);
	localparam logic [pst_pkg::ACC_W-1:0] STEP = pst_pkg::ACC_W'(TB_KHZ);
	localparam logic [pst_pkg::ACC_W-1:0] MODULUS = pst_pkg::ACC_W'(REF_KHZ);

	logic [pst_pkg::ACC_W-1:0] acc_q;

	// Phase accumulator: exact average rate even when the ratio is not whole
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			acc_q <= '0;
			tick_q <= 1'b0;
		end else if (acc_q >= MODULUS - STEP) begin
			acc_q <= acc_q - (MODULUS - STEP);
			tick_q <= 1'b1;
		end else begin
			acc_q <= acc_q + STEP;
			tick_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- logic/phase_window.sv ----
// One programmable phase window: active from the start count up to the end count
`timescale 1ns/1ns
`default_nettype none
module phase_window #(
	parameter int CNT_W = pst_pkg::CNT_W
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic [CNT_W-1:0] count,
	input wire logic [CNT_W-1:0] start_cnt,
	input wire logic [CNT_W-1:0] end_cnt,
	output logic active_q
);
	// Half-open window; an end at or below the start gives no pulse at all
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			active_q <= 1'b0;
		end else begin
			active_q <= run && (count >= start_cnt) && (count < end_cnt);
		end
	end
endmodule
`default_nettype wire

// ---- logic/pulse_sequence_timer_regs.sv ----
// Pulse sequence timer: register bank, period counter, phase windows and diagnostic pin mux
//
// How it works
// RL1: Ambient-1 convert phase ends when the period counter reaches its end count.
// RL2: ADC reset 0 phase runs from its start to end count; both reset to zero.
// RL3: ADC reset 1 phase runs from its own start count to its end count.
// RL4: ADC reset 2 phase runs from its own start count to its end count.
// RL5: ADC reset 3 phase runs from start to end count; both zero after reset.
// RL6: Software writes zeros above bit 15 of every count register.
// RL7: Period counter wraps at the programmed repetition count of timebase cycles.
// RL8: Software keeps the repetition count between 800 and 64000.
// RL9: Control holds selector in bits 11..9, enable in bit 8, bit 1 reads one.
// RL10: Selector routes emitter-2 to photodiode pin, emitter-1 to emitter pin; 101-111 nothing.
// RL11: Software keeps the spare register all zero.
// RL12: With enable clear counter and phases stay idle; setting it counts from zero.
`timescale 1ns/1ns
`default_nettype none
module pulse_sequence_timer_regs #(
	parameter int CNT_W = pst_pkg::CNT_W,
	parameter int REF_KHZ = pst_pkg::REF_KHZ,
	parameter int TB_KHZ = pst_pkg::TB_KHZ
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [pst_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pst_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pst_pkg::DATA_W-1:0] reg_rdata,
	input wire pst_pkg::diag_src_t diag_src,
	output pst_pkg::phase_t phases,
	output logic [CNT_W-1:0] period_count,
	output logic photodiode_alarm_pin,
	output logic emitter_alarm_pin
);
	// Count register bank, addressed by index
	logic [CNT_W-1:0] cnt_regs_q [pst_pkg::NUM_CNT];
	logic [2:0] diag_pin_selector_q;
	logic timer_enable_bit_q;
	logic [pst_pkg::DATA_W-1:0] spare_reserved_q;
	logic [pst_pkg::DATA_W-1:0] rdata_q;
	logic [CNT_W-1:0] cnt_q;
	logic tick;
	logic amb1_active;
	logic [3:0] rst_active;
	logic pd_alarm_q;
	logic em_alarm_q;
	logic [7:0] cnt_idx;
	logic cnt_hit;
	logic [CNT_W-1:0] rep_period;
	logic [CNT_W-1:0] wrap_at;

	// Bank decode: offsets of the count registers are contiguous
	assign cnt_idx = reg_addr - pst_pkg::CNT_BASE_OFS;
	assign cnt_hit = (reg_addr >= pst_pkg::CNT_BASE_OFS) && (cnt_idx < 8'(pst_pkg::NUM_CNT));
	assign rep_period = cnt_regs_q[pst_pkg::IDX_REP_PERIOD];
	// Last count of the period; a zero period degenerates to a counter stuck at zero
	assign wrap_at = (rep_period == '0) ? '0 : rep_period - CNT_W'(1);

	// Count register writes; the upper byte is dropped so it always reads zero
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			for (int i = 0; i < pst_pkg::NUM_CNT; i++) begin
				cnt_regs_q[i] <= pst_pkg::CNT_RESET; // RL2 RL5
			end
		end else if (reg_wr && cnt_hit) begin
			cnt_regs_q[cnt_idx[3:0]] <= reg_wdata[CNT_W-1:0]; // RL6
		end
	end

	// Control register: selector and enable are the only stored fields
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			diag_pin_selector_q <= pst_pkg::SEL_RESET;
			timer_enable_bit_q <= 1'b0;
		end else if (reg_wr && reg_addr == pst_pkg::OFS_CONTROL) begin
			diag_pin_selector_q <= reg_wdata[pst_pkg::CTRL_SEL_MSB:pst_pkg::CTRL_SEL_LSB]; // RL9
			timer_enable_bit_q <= reg_wdata[pst_pkg::CTRL_EN_BIT]; // RL9
		end
	end

	// Spare register is stored as written so software can read back what it left there
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			spare_reserved_q <= pst_pkg::SPARE_RESET;
		end else if (reg_wr && reg_addr == pst_pkg::OFS_SPARE) begin
			spare_reserved_q <= reg_wdata; // RL11
		end
	end

	// Read data in the cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			if (cnt_hit) begin
				rdata_q <= pst_pkg::DATA_W'(cnt_regs_q[cnt_idx[3:0]]);
			end else if (reg_addr == pst_pkg::OFS_CONTROL) begin
				rdata_q <= '0;
				rdata_q[pst_pkg::CTRL_SEL_MSB:pst_pkg::CTRL_SEL_LSB] <= diag_pin_selector_q; // RL9
				rdata_q[pst_pkg::CTRL_EN_BIT] <= timer_enable_bit_q;
				rdata_q[pst_pkg::CTRL_ONE_BIT] <= 1'b1;
			end else if (reg_addr == pst_pkg::OFS_SPARE) begin
				rdata_q <= spare_reserved_q;
			end else if (reg_addr == pst_pkg::OFS_STATUS) begin
				rdata_q <= pst_pkg::DATA_W'(cnt_q);
			end else begin
				rdata_q <= '0;
			end
		end
	end

	// Timebase enable pulse
	tb_tick_gen #(
		.REF_KHZ(REF_KHZ),
		.TB_KHZ(TB_KHZ)
	) u_tick (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.tick_q(tick)
	);

	// Period counter: held at zero while disabled, so enabling always starts a fresh period
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cnt_q <= '0;
		end else if (!timer_enable_bit_q) begin
			cnt_q <= '0; // RL12
		end else if (tick) begin
			if (cnt_q >= wrap_at) begin
				cnt_q <= '0; // RL7
			end else begin
				cnt_q <= cnt_q + CNT_W'(1);
			end
		end
	end

	// Ambient-1 convert window
	phase_window #(
		.CNT_W(CNT_W)
	) u_amb1 (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.run(timer_enable_bit_q),
		.count(cnt_q),
		.start_cnt(cnt_regs_q[pst_pkg::IDX_AMB1_START]),
		.end_cnt(cnt_regs_q[pst_pkg::IDX_AMB1_END]),
		.active_q(amb1_active)
	); // RL1

	// Four ADC reset windows, start and end registers sit pairwise in the bank
	for (genvar g = 0; g < 4; g++) begin : g_rst
		phase_window #(
			.CNT_W(CNT_W)
		) u_rst (
			.ref_clk(ref_clk),
			.rstn(rstn),
			.run(timer_enable_bit_q),
			.count(cnt_q),
			.start_cnt(cnt_regs_q[pst_pkg::IDX_RST_BASE + 2 * g]),
			.end_cnt(cnt_regs_q[pst_pkg::IDX_RST_BASE + 2 * g + 1]),
			.active_q(rst_active[g])
		); // RL2 RL3 RL4 RL5
	end

	// Diagnostic pins; idle low for the unused selector codes
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			pd_alarm_q <= 1'b0;
			em_alarm_q <= 1'b0;
		end else begin
			case (diag_pin_selector_q)
				pst_pkg::SEL_SAMPLE: begin
					pd_alarm_q <= diag_src.led2.sample; // RL10
					em_alarm_q <= diag_src.led1.sample;
				end
				pst_pkg::SEL_LED_PULSE: begin
					pd_alarm_q <= diag_src.led2.led_pulse;
					em_alarm_q <= diag_src.led1.led_pulse;
				end
				pst_pkg::SEL_AMB_SAMPLE: begin
					pd_alarm_q <= diag_src.led2.amb_sample;
					em_alarm_q <= diag_src.led1.amb_sample;
				end
				pst_pkg::SEL_CONVERT: begin
					pd_alarm_q <= diag_src.led2.convert;
					em_alarm_q <= diag_src.led1.convert;
				end
				pst_pkg::SEL_AMB_CONVERT: begin
					// Emitter-1 ambient convert is this block's own window
					pd_alarm_q <= diag_src.led2.amb_convert;
					em_alarm_q <= amb1_active;
				end
				default: begin
					pd_alarm_q <= 1'b0; // RL10
					em_alarm_q <= 1'b0;
				end
			endcase
		end
	end

	assign reg_rdata = rdata_q;
	assign phases.amb1_convert = amb1_active;
	assign phases.adc_reset = rst_active;
	assign period_count = cnt_q;
	assign photodiode_alarm_pin = pd_alarm_q;
	assign emitter_alarm_pin = em_alarm_q;

	// Checks on the timing engine
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	property p_amb1_end;
		timer_enable_bit_q && cnt_q == cnt_regs_q[pst_pkg::IDX_AMB1_END] |=> !phases.amb1_convert;
	endproperty
	a_amb1_end: assert property (p_amb1_end) else $error("ambient convert not ended at end count"); // RL1

	property p_rst0_window;
		timer_enable_bit_q && cnt_q == cnt_regs_q[2] && cnt_regs_q[2] < cnt_regs_q[3]
			|=> phases.adc_reset[0];
	endproperty
	a_rst0_window: assert property (p_rst0_window) else $error("adc reset 0 not active at start"); // RL2

	property p_rst1_end;
		timer_enable_bit_q && cnt_q == cnt_regs_q[5] ##1 cnt_q == $past(cnt_q) |-> !phases.adc_reset[1];
	endproperty
	a_rst1_end: assert property (p_rst1_end) else $error("adc reset 1 active at end count"); // RL3

	property p_rst2_inside;
		timer_enable_bit_q && cnt_q > cnt_regs_q[6] && cnt_q < cnt_regs_q[7] |=> phases.adc_reset[2];
	endproperty
	a_rst2_inside: assert property (p_rst2_inside) else $error("adc reset 2 idle inside window"); // RL4

	property p_rst3_outside;
		cnt_q < cnt_regs_q[8] || cnt_q >= cnt_regs_q[9] |=> !phases.adc_reset[3];
	endproperty
	a_rst3_outside: assert property (p_rst3_outside) else $error("adc reset 3 active outside window"); // RL5

	property p_wrap;
		timer_enable_bit_q && tick && rep_period != '0 && cnt_q == rep_period - CNT_W'(1)
			|=> cnt_q == '0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("period counter did not wrap"); // RL7

	property p_ctrl_read;
		reg_rd && reg_addr == pst_pkg::OFS_CONTROL
			|=> reg_rdata[1] && reg_rdata[11:8] == $past({diag_pin_selector_q, timer_enable_bit_q})
			&& reg_rdata[23:12] == '0;
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read layout wrong"); // RL9

	property p_diag_off;
		diag_pin_selector_q > 3'b100 |=> !photodiode_alarm_pin && !emitter_alarm_pin;
	endproperty
	a_diag_off: assert property (p_diag_off) else $error("alarm pin driven for unused code"); // RL10

	property p_diag_amb;
		diag_pin_selector_q == 3'b100 ##1 diag_pin_selector_q == 3'b100
			|-> emitter_alarm_pin == $past(amb1_active);
	endproperty
	a_diag_amb: assert property (p_diag_amb) else $error("emitter pin not ambient convert"); // RL10

	property p_disabled;
		!timer_enable_bit_q |=> cnt_q == '0 && phases == '0;
	endproperty
	a_disabled: assert property (p_disabled) else $error("timer active while disabled"); // RL12

	// Window edges: each phase rises at its start count and stays low outside its window
	property p_amb1_start;
		timer_enable_bit_q && cnt_q == cnt_regs_q[pst_pkg::IDX_AMB1_START]
			&& cnt_q < cnt_regs_q[pst_pkg::IDX_AMB1_END] |=> phases.amb1_convert;
	endproperty
	a_amb1_start: assert property (p_amb1_start) else $error("ambient convert not active at start"); // RL1

	property p_amb1_outside;
		cnt_q < cnt_regs_q[pst_pkg::IDX_AMB1_START] || cnt_q >= cnt_regs_q[pst_pkg::IDX_AMB1_END]
			|=> !phases.amb1_convert;
	endproperty
	a_amb1_outside: assert property (p_amb1_outside) else $error("ambient convert outside window"); // RL1

	property p_rst0_outside;
		cnt_q < cnt_regs_q[2] || cnt_q >= cnt_regs_q[3] |=> !phases.adc_reset[0];
	endproperty
	a_rst0_outside: assert property (p_rst0_outside) else $error("adc reset 0 active outside window"); // RL2

	property p_rst1_start;
		timer_enable_bit_q && cnt_q == cnt_regs_q[4] && cnt_q < cnt_regs_q[5] |=> phases.adc_reset[1];
	endproperty
	a_rst1_start: assert property (p_rst1_start) else $error("adc reset 1 not active at start"); // RL3

	property p_rst2_start;
		timer_enable_bit_q && cnt_q == cnt_regs_q[6] && cnt_q < cnt_regs_q[7] |=> phases.adc_reset[2];
	endproperty
	a_rst2_start: assert property (p_rst2_start) else $error("adc reset 2 not active at start"); // RL4

	property p_rst2_outside;
		cnt_q < cnt_regs_q[6] || cnt_q >= cnt_regs_q[7] |=> !phases.adc_reset[2];
	endproperty
	a_rst2_outside: assert property (p_rst2_outside) else $error("adc reset 2 active outside window"); // RL4

	property p_rst3_start;
		timer_enable_bit_q && cnt_q == cnt_regs_q[8] && cnt_q < cnt_regs_q[9] |=> phases.adc_reset[3];
	endproperty
	a_rst3_start: assert property (p_rst3_start) else $error("adc reset 3 not active at start"); // RL5

	// While enabled, counter moves by one per timebase pulse until it wraps, and never between pulses
	property p_count_step;
		timer_enable_bit_q && tick && cnt_q + CNT_W'(1) < rep_period
			|=> cnt_q == $past(cnt_q) + CNT_W'(1);
	endproperty
	a_count_step: assert property (p_count_step) else $error("period counter did not advance"); // RL7

	property p_count_hold;
		timer_enable_bit_q && !tick |=> $stable(cnt_q);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("period counter moved without tick"); // RL7

	property p_tick_single;
		tick |=> !tick;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("timebase pulse longer than one cycle"); // RL7

	property p_ctrl_write;
		reg_wr && reg_addr == pst_pkg::OFS_CONTROL
			|=> timer_enable_bit_q == $past(reg_wdata[pst_pkg::CTRL_EN_BIT])
			&& diag_pin_selector_q == $past(reg_wdata[pst_pkg::CTRL_SEL_MSB:pst_pkg::CTRL_SEL_LSB]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored"); // RL9

	property p_diag_sample;
		diag_pin_selector_q == pst_pkg::SEL_SAMPLE |=> photodiode_alarm_pin == $past(diag_src.led2.sample)
			&& emitter_alarm_pin == $past(diag_src.led1.sample);
	endproperty
	a_diag_sample: assert property (p_diag_sample) else $error("alarm pins not sample pulse"); // RL10

	property p_diag_pulse;
		diag_pin_selector_q == pst_pkg::SEL_LED_PULSE |=> photodiode_alarm_pin == $past(diag_src.led2.led_pulse)
			&& emitter_alarm_pin == $past(diag_src.led1.led_pulse);
	endproperty
	a_diag_pulse: assert property (p_diag_pulse) else $error("alarm pins not emitter pulse"); // RL10

	property p_diag_convert;
		diag_pin_selector_q == pst_pkg::SEL_CONVERT |=> photodiode_alarm_pin == $past(diag_src.led2.convert)
			&& emitter_alarm_pin == $past(diag_src.led1.convert);
	endproperty
	a_diag_convert: assert property (p_diag_convert) else $error("alarm pins not convert phase"); // RL10

	property p_enable_start;
		$rose(timer_enable_bit_q) |-> cnt_q == '0;
	endproperty
	a_enable_start: assert property (p_enable_start) else $error("enable did not start from zero"); // RL12
endmodule
`default_nettype wire

// ---- bench/pulse_sequence_timer_regs_tb.sv ----
// Self-checking bench for the pulse sequence timer register block
`timescale 1ns/1ns
`default_nettype none
module pulse_sequence_timer_regs_tb;
	logic ref_clk;
	logic rstn;
	logic [7:0] reg_addr;
	logic [23:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [23:0] reg_rdata;
	pst_pkg::diag_src_t diag_src;
	pst_pkg::phase_t phases;
	logic [15:0] period_count;
	logic pd_pin;
	logic em_pin;
	logic [23:0] rv;
	int failures;
	int check_count;

	pulse_sequence_timer_regs dut_u (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.diag_src(diag_src),
		.phases(phases),
		.period_count(period_count),
		.photodiode_alarm_pin(pd_pin),
		.emitter_alarm_pin(em_pin)
	);

	// 50 MHz reference clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		check_count++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, g);
			failures++;
		end
	endtask

	// One-cycle write strobe, released at the next edge
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data is looked at only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [23:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	function automatic logic win(input logic [15:0] c, input logic [15:0] s, input logic [15:0] e);
		return (c >= s) && (c < e);
	endfunction

	task automatic t_reset();
		for (int a = 8'h15; a <= 8'h1F; a++) begin
			rd(8'(a), rv);
			chk("reset value", (a == 8'h1E) ? 24'h000002 : 24'h000000, rv);
		end
		$display("test reset done");
	endtask

	task automatic t_regs();
		wr(8'h1B, 24'h00FFFF);
		rd(8'h1B, rv);
		chk("count upper bits", 24'h00FFFF, rv);
		wr(8'h1E, 24'hFFFFFF);
		rd(8'h1E, rv);
		chk("control fields", 24'h000F02, rv);
		wr(8'h1E, 24'h000000);
		wr(8'h1B, 24'h000000);
		rd(8'h40, rv);
		chk("unmapped read", 24'h000000, rv);
		$display("test regs done");
	endtask

	// Timer idle here, so the internal ambient window keeps the emitter pin low on code 100
	task automatic t_diag();
		logic [9:0] src;
		for (int c = 0; c < 8; c++) begin
			src = (c < 5) ? {2{5'h10 >> c}} : 10'h3FF;
			wr(8'h1E, 24'(c) << 9);
			diag_src <= src;
			repeat (2) @(posedge ref_clk);
			#1;
			chk("pd pin", 24'(c < 5), 24'(pd_pin));
			chk("emitter pin", 24'(c < 4), 24'(em_pin));
			@(posedge ref_clk);
			diag_src <= ~src;
			repeat (2) @(posedge ref_clk);
			#1;
			chk("pins other", 24'h0, 24'({pd_pin, em_pin}));
		end
		wr(8'h1E, 24'h000000);
		$display("test diag done");
	endtask

	// Shortest legal period; one wrap takes about ten thousand reference cycles
	task automatic t_timer();
		logic [15:0] prev;
		logic [4:0] ex;
		logic wrapped;
		int wrap_cyc;
		wrapped = 1'b0;
		wrap_cyc = 0;
		wr(8'h13, 24'h1);
		wr(8'h14, 24'h3);
		for (int i = 0; i < 4; i++) begin
			wr(8'h15 + 8'(2 * i), 24'(2 + i));
			wr(8'h16 + 8'(2 * i), 24'(4 + i));
		end
		wr(8'h1D, 24'h000320);
		wr(8'h1E, 24'h000100);
		prev = 16'h0;
		for (int i = 1; i <= 10500; i++) begin
			@(posedge ref_clk);
			#1;
			ex[4] = win(prev, 16'h1, 16'h3);
			for (int k = 0; k < 4; k++) ex[k] = win(prev, 16'(2 + k), 16'(4 + k));
			chk("phases", 24'(ex), 24'(phases));
			chk("count bound", 24'h1, 24'(period_count < 16'h0320));
			if (!wrapped && period_count === 16'h0 && prev === 16'h031F) begin
				wrapped = 1'b1;
				wrap_cyc = i;
			end
			prev = period_count;
		end
		chk("wrap", 24'h1, 24'(wrapped));
		// 800 pulses of the 4 MHz timebase are 10000 reference cycles, give or take one pulse
		chk("period length", 24'h1, 24'(wrap_cyc >= 9980 && wrap_cyc <= 10020));
		$display("test timer done");
	endtask

	task automatic t_enable();
		wr(8'h1E, 24'h000000);
		repeat (150) begin
			@(posedge ref_clk);
			#1;
		end
		chk("idle count", 24'h0, 24'(period_count));
		chk("idle phases", 24'h0, 24'(phases));
		rd(8'h30, rv);
		chk("idle status", 24'h0, rv);
		wr(8'h1E, 24'h000100);
		for (int i = 0; i < 100; i++) begin
			@(posedge ref_clk);
			#1;
			if (period_count !== 16'h0) break;
		end
		chk("first count", 24'h1, 24'(period_count));
		$display("test enable done");
	endtask

	// Main sequence: reset for 10 cycles, then each scenario
	initial begin
		failures = 0;
		check_count = 0;
		rstn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 24'h000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		diag_src = '0;
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		t_reset();
		t_regs();
		t_diag();
		t_timer();
		t_enable();
		finish_test();
	end
endmodule
`default_nettype wire
